/* common/fsbe_consts.svh */
// Purpose: offsets, field positions, command bytes and timing counts
// Assumes: 200 MHz system clock
// Notes:   shared by the controller, its bus-cycle engine and the bench
`ifndef FSBE_CONSTS_SVH
`define FSBE_CONSTS_SVH

// ----------------------------------------------------------------
// controller register map (byte addresses, one word each)
// ----------------------------------------------------------------
`define FSBE_OFF_CTRL     8'h00
`define FSBE_OFF_ADDR     8'h04
`define FSBE_OFF_STATUS   8'h08
`define FSBE_OFF_IRQ_STAT 8'h0c
`define FSBE_OFF_IRQ_CLR  8'h10
`define FSBE_OFF_IRQ_EN   8'h14

// ----------------------------------------------------------------
// control register bits (write one to launch)
// ----------------------------------------------------------------
`define FSBE_CTRL_ERASE   0
`define FSBE_CTRL_RDST    1
`define FSBE_CTRL_CLRST   2
`define FSBE_CTRL_ARRAY   3

// status register of controller: bits above the flash status
`define FSBE_ST_BUSY      8
`define FSBE_ST_ERROR     9

// interrupt bits
`define FSBE_IRQ_DONE     0
`define FSBE_IRQ_ERR      1
`define FSBE_IRQ_W        2

// ----------------------------------------------------------------
// flash command bytes
// ----------------------------------------------------------------
`define FSBE_CMD_ERASE_SETUP 8'h20
`define FSBE_CMD_CONFIRM     8'hd0
`define FSBE_CMD_READ_STATUS 8'h70
`define FSBE_CMD_READ_ARRAY  8'hff
`define FSBE_CMD_CLEAR_STAT  8'h50

// ----------------------------------------------------------------
// flash status word fields
// ----------------------------------------------------------------
`define FSBE_SR_READY     7
`define FSBE_SR_ERSUSP    6
`define FSBE_SR_ERERR     5
`define FSBE_SR_WRERR     4
`define FSBE_SR_SUPPLY    3
`define FSBE_SR_WRSUSP    2
`define FSBE_SR_PROT      1
`define FSBE_SR_POLL_MASK 8'hfe
`define FSBE_SR_ERR_MASK  8'h3a

// ----------------------------------------------------------------
// timing: figures in ns, counts rounded up to whole cycles
// ----------------------------------------------------------------
`define FSBE_CLK_NS       5
`define FSBE_T_SETUP_NS   20
`define FSBE_T_STROBE_NS  60
`define FSBE_T_HOLD_NS    20
`define FSBE_SETUP_CYC  ((`FSBE_T_SETUP_NS + `FSBE_CLK_NS - 1) / `FSBE_CLK_NS)
`define FSBE_STROBE_CYC ((`FSBE_T_STROBE_NS + `FSBE_CLK_NS - 1) / `FSBE_CLK_NS)
`define FSBE_HOLD_CYC   ((`FSBE_T_HOLD_NS + `FSBE_CLK_NS - 1) / `FSBE_CLK_NS)
`define FSBE_SYNC_CYC   2

`endif

/* common/fsbe_pkg.sv */
// Purpose: types shared by the flash erase controller
// Assumes: 8-bit flash data, 20-bit flash address
// Notes:   constants live in fsbe_consts.svh
package fsbe_pkg;

	// one flash bus cycle request
	typedef struct packed
	{
		logic        wr;
		logic [19:0] addr;
		logic [7:0]  data;
	} fsbe_req_t;

	// flash pins driven by the controller
	typedef struct packed
	{
		logic        ce_n;
		logic        we_n;
		logic        oe_n;
		logic [19:0] addr;
		logic [7:0]  dq_o;
		logic        dq_oe;
	} fsbe_pins_t;

	// operation sequencer
	typedef enum logic [4:0]
	{
		FSBE_IDLE  = 5'b00001,
		FSBE_SETUP = 5'b00010,
		FSBE_CMDW  = 5'b00100,
		FSBE_POLL  = 5'b01000,
		FSBE_DONE  = 5'b10000
	} fsbe_state_t;

	// bus-cycle phases
	typedef enum logic [3:0]
	{
		FSBE_PH_IDLE   = 4'b0001,
		FSBE_PH_SETUP  = 4'b0010,
		FSBE_PH_STROBE = 4'b0100,
		FSBE_PH_HOLD   = 4'b1000
	} fsbe_phase_t;

endpackage : fsbe_pkg

/* src/fsbe_bus_cycle.sv */
// Purpose: one asynchronous flash read or write cycle with timed strobes
// Assumes: req stays stable while req_valid is high and until done
// Notes:   read data passes two flops before capture
`timescale 1ns/1ps
`include "fsbe_consts.svh"
module fsbe_bus_cycle
	import fsbe_pkg::*;
(
	input  wire logic       clk_sys,   // system clock
	input  wire logic       rst_n,     // async reset, active low
	input  wire fsbe_req_t  req,       // cycle request
	input  wire logic       req_valid, // request pending
	output fsbe_pins_t      pins,      // flash pins, registered
	output logic            done,      // one-cycle pulse at end
	output logic [7:0]      rdata,     // captured read data
	input  wire logic [7:0] dq_i       // flash data pins
);

	fsbe_phase_t phase_reg;
	logic [7:0]  cnt_reg;
	logic [7:0]  dq_s1_reg;
	logic [7:0]  dq_s2_reg;

	// ----------------------------------------------------------------
	// input synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dq_s1_reg <= 8'h00;
			dq_s2_reg <= 8'h00;
		end
		else
		begin
			dq_s1_reg <= dq_i;
			dq_s2_reg <= dq_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// strobe sequencing
	// ----------------------------------------------------------------
	// reads stretch the strobe by the synchroniser depth so the
	// sampled byte is the one the flash drove under oe
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_reg <= FSBE_PH_IDLE;
			cnt_reg   <= 8'h00;
			pins      <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 20'h00000,
				dq_o: 8'h00, dq_oe: 1'b0};
			done      <= 1'b0;
			rdata     <= 8'h00;
		end
		else
		begin
			done <= 1'b0;
			unique case (phase_reg)
				FSBE_PH_IDLE:
				begin
					if (req_valid && !done)
					begin
						pins.ce_n  <= 1'b0;
						pins.addr  <= req.addr;
						pins.dq_o  <= req.data;
						pins.dq_oe <= req.wr;
						cnt_reg    <= 8'(`FSBE_SETUP_CYC);
						phase_reg  <= FSBE_PH_SETUP;
					end
				end
				FSBE_PH_SETUP:
				begin
					if (cnt_reg > 8'h01)
						cnt_reg <= cnt_reg - 8'h01;
					else
					begin
						pins.we_n <= ~req.wr;
						pins.oe_n <= req.wr;
						cnt_reg   <= req.wr ? 8'(`FSBE_STROBE_CYC)
							: 8'(`FSBE_STROBE_CYC + `FSBE_SYNC_CYC);
						phase_reg <= FSBE_PH_STROBE;
					end
				end
				FSBE_PH_STROBE:
				begin
					if (cnt_reg > 8'h01)
						cnt_reg <= cnt_reg - 8'h01;
					else
					begin
						pins.we_n <= 1'b1;
						pins.oe_n <= 1'b1;
						if (!req.wr)
							rdata <= dq_s2_reg;
						cnt_reg   <= 8'(`FSBE_HOLD_CYC);
						phase_reg <= FSBE_PH_HOLD;
					end
				end
				FSBE_PH_HOLD:
				begin
					if (cnt_reg > 8'h01)
						cnt_reg <= cnt_reg - 8'h01;
					else
					begin
						pins.ce_n  <= 1'b1;
						pins.dq_oe <= 1'b0;
						done       <= 1'b1;
						phase_reg  <= FSBE_PH_IDLE;
					end
				end
			endcase
		end
	end

endmodule : fsbe_bus_cycle

/* src/fsbe_ctrl.sv */
// Purpose: host controller for block erase and status handling of a NOR flash
// Assumes: flash on an asynchronous 8-bit bus, software over AXI4-Lite
// Notes:   one operation at a time; launches while busy are dropped
//
// Summary of operation
// - completion is seen when status bit 7 reads ready, and only then are the other bits used.
// - the reserved status bit 0 is masked out whenever status is polled.
// - an erase is the byte 20H to any address, then D0H inside the target block.
// - erases may be repeated and the full status check done after each or after a series.
// - after the last operation the host writes FFH to return the flash to array read.
// - after any error the host clears status before a retry.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fsbe_consts.svh"
module fsbe_ctrl
	import fsbe_pkg::*;
(
	input  wire logic        clk_sys,          // system clock, 200 MHz
	input  wire logic        rst_n,            // async reset, active low
	input  wire logic [7:0]  s_axi_awaddr,     // write address
	input  wire logic        s_axi_awvalid,    // write address valid
	output logic             s_axi_awready,    // write address ready
	input  wire logic [31:0] s_axi_wdata,      // write data
	input  wire logic [3:0]  s_axi_wstrb,      // write byte enables
	input  wire logic        s_axi_wvalid,     // write data valid
	output logic             s_axi_wready,     // write data ready
	output logic [1:0]       s_axi_bresp,      // write response
	output logic             s_axi_bvalid,     // write response valid
	input  wire logic        s_axi_bready,     // write response ready
	input  wire logic [7:0]  s_axi_araddr,     // read address
	input  wire logic        s_axi_arvalid,    // read address valid
	output logic             s_axi_arready,    // read address ready
	output logic [31:0]      s_axi_rdata,      // read data
	output logic [1:0]       s_axi_rresp,      // read response
	output logic             s_axi_rvalid,     // read data valid
	input  wire logic        s_axi_rready,     // read data ready
	output fsbe_pins_t       flash,            // flash strobes, address, data out
	input  wire logic [7:0]  flash_dq_i,       // flash data in
	output logic             reset_powerdown_n, // flash reset, active low
	input  wire logic        ready_busy_out,   // flash ready/busy pin
	output logic             irq               // level interrupt
);

	fsbe_state_t state_reg;
	fsbe_req_t   req_reg;
	logic        req_valid_reg;
	logic        cyc_done;
	logic [7:0]  cyc_rdata;
	logic [19:0] addr_reg;
	logic [7:0]  status_reg;
	logic [3:0]  op_reg;
	logic [`FSBE_IRQ_W-1:0] irq_stat_reg;
	logic [`FSBE_IRQ_W-1:0] irq_en_reg;
	logic [`FSBE_IRQ_W-1:0] irq_set;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_fire;
	logic        rb_s1_reg;
	logic        rb_s2_reg;
	logic [7:0]  polled;

	// ----------------------------------------------------------------
	// flash bus cycle engine
	// ----------------------------------------------------------------
	fsbe_bus_cycle u_cycle
	(
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.req       (req_reg),
		.req_valid (req_valid_reg),
		.pins      (flash),
		.done      (cyc_done),
		.rdata     (cyc_rdata),
		.dq_i      (flash_dq_i)
	);
	// ready/busy synchroniser; the flash reset trails ours by one cycle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rb_s1_reg         <= 1'b0;
			rb_s2_reg         <= 1'b0;
			reset_powerdown_n <= 1'b0;
		end
		else
		begin
			rb_s1_reg         <= ready_busy_out;
			rb_s2_reg         <= rb_s1_reg;
			reset_powerdown_n <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	// address and data are held until both have arrived
	assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h00000000;
			w_strb_reg    <= 4'h0;
		end
		else
		begin
			if (s_axi_awready && s_axi_awvalid)
			begin
				aw_addr_reg   <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wready && s_axi_wvalid)
			begin
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_reg inside {`FSBE_OFF_CTRL, `FSBE_OFF_ADDR,
					`FSBE_OFF_IRQ_CLR, `FSBE_OFF_IRQ_EN}) ? 2'b00 : 2'b10;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end
	// read side answers one cycle after the address is taken
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
		end
		else if (s_axi_arready && s_axi_arvalid)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'b00;
			unique case (s_axi_araddr)
				`FSBE_OFF_ADDR:     s_axi_rdata <= {12'h000, addr_reg};
				`FSBE_OFF_STATUS:   s_axi_rdata <= {21'h000000, rb_s2_reg,
					|(status_reg & `FSBE_SR_ERR_MASK), !state_reg[0], status_reg};
				`FSBE_OFF_IRQ_STAT: s_axi_rdata <= {30'h00000000, irq_stat_reg};
				`FSBE_OFF_IRQ_EN:   s_axi_rdata <= {30'h00000000, irq_en_reg};
				`FSBE_OFF_CTRL, `FSBE_OFF_IRQ_CLR: s_axi_rdata <= 32'h00000000;
				default: {s_axi_rresp, s_axi_rdata} <= {2'b10, 32'h00000000};
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
	// target block address, byte-lane masked
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			addr_reg <= 20'h00000;
		else if (wr_fire && aw_addr_reg == `FSBE_OFF_ADDR)
		begin
			if (w_strb_reg[0]) addr_reg[7:0]   <= w_data_reg[7:0];
			if (w_strb_reg[1]) addr_reg[15:8]  <= w_data_reg[15:8];
			if (w_strb_reg[2]) addr_reg[19:16] <= w_data_reg[19:16];
		end
	end

	// ----------------------------------------------------------------
	// operation sequencer
	// ----------------------------------------------------------------
	// reserved bit 0 never reaches software or the error logic
	assign polled = cyc_rdata & `FSBE_SR_POLL_MASK;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg     <= FSBE_IDLE;
			req_reg       <= '{wr: 1'b0, addr: 20'h00000, data: 8'h00};
			req_valid_reg <= 1'b0;
			op_reg        <= 4'h0;
			status_reg    <= 8'h00;
		end
		else
		begin
			unique case (state_reg)
				FSBE_IDLE:
				begin
					// launch only with a one-hot command and write lane 0
					if (wr_fire && aw_addr_reg == `FSBE_OFF_CTRL && w_strb_reg[0]
						&& $onehot(w_data_reg[3:0]))
					begin
						op_reg        <= w_data_reg[3:0];
						req_valid_reg <= 1'b1;
						req_reg.wr    <= 1'b1;
						req_reg.addr  <= 20'h00000;
						if (w_data_reg[`FSBE_CTRL_ERASE])
						begin
							req_reg.data <= `FSBE_CMD_ERASE_SETUP;
							state_reg    <= FSBE_SETUP;
						end
						else
						begin
							req_reg.data <= w_data_reg[`FSBE_CTRL_RDST]
								? `FSBE_CMD_READ_STATUS
								: w_data_reg[`FSBE_CTRL_CLRST] ? `FSBE_CMD_CLEAR_STAT
								: `FSBE_CMD_READ_ARRAY;
							state_reg <= FSBE_CMDW;
						end
					end
				end
				FSBE_SETUP:
				begin
					if (cyc_done)
					begin
						req_reg.data <= `FSBE_CMD_CONFIRM;
						req_reg.addr <= addr_reg;
						state_reg    <= FSBE_CMDW;
					end
				end
				FSBE_CMDW:
				begin
					if (cyc_done)
					begin
						// erase confirm and read status leave the flash in status mode
						req_reg.wr    <= 1'b0;
						req_valid_reg <= op_reg[`FSBE_CTRL_ERASE] || op_reg[`FSBE_CTRL_RDST];
						state_reg     <= (op_reg[`FSBE_CTRL_ERASE] || op_reg[`FSBE_CTRL_RDST])
							? FSBE_POLL : FSBE_DONE;
						if (op_reg[`FSBE_CTRL_CLRST])
							status_reg <= 8'h00;
					end
				end
				FSBE_POLL:
				begin
					// keep reading until the engine reports ready, then keep bits 7 to 1 (bit 0 masked)
					if (cyc_done && polled[`FSBE_SR_READY])
					begin
						req_valid_reg <= 1'b0;
						status_reg    <= polled;
						state_reg     <= FSBE_DONE;
					end
				end
				FSBE_DONE:
					state_reg <= FSBE_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// error (bit 1) covers status bits 5, 4, 3 and 1 as latched when ready; done is bit 0
	assign irq_set = {(state_reg == FSBE_POLL) && cyc_done && polled[`FSBE_SR_READY]
		&& |(polled & `FSBE_SR_ERR_MASK), state_reg == FSBE_DONE};

	// set wins over a clear written in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_stat_reg <= '0;
			irq_en_reg   <= '0;
			irq          <= 1'b0;
		end
		else
		begin
			if (wr_fire && aw_addr_reg == `FSBE_OFF_IRQ_CLR && w_strb_reg[0])
				irq_stat_reg <= (irq_stat_reg & ~w_data_reg[`FSBE_IRQ_W-1:0]) | irq_set;
			else
				irq_stat_reg <= irq_stat_reg | irq_set;
			if (wr_fire && aw_addr_reg == `FSBE_OFF_IRQ_EN && w_strb_reg[0])
				irq_en_reg <= w_data_reg[`FSBE_IRQ_W-1:0];
			irq <= |(irq_stat_reg & irq_en_reg);
		end
	end
endmodule : fsbe_ctrl

/* tb/fsbe_ctrl_props.sv */
// Purpose: port-level checks of the flash erase controller
// Assumes: one clock domain, async active-low reset
// Notes:   bound to fsbe_ctrl at the foot of this file
`timescale 1ns/1ps
`include "fsbe_consts.svh"
module fsbe_ctrl_props
	import fsbe_pkg::*;
(
	input wire logic        clk_sys,       // clock
	input wire logic        rst_n,         // reset
	input wire logic        s_axi_awvalid, // aw valid
	input wire logic        s_axi_awready, // aw ready
	input wire logic        s_axi_bvalid,  // b valid
	input wire logic        s_axi_bready,  // b ready
	input wire logic [7:0]  s_axi_araddr,  // ar address
	input wire logic        s_axi_arvalid, // ar valid
	input wire logic        s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata,   // r data
	input wire logic        s_axi_rvalid,  // r valid
	input wire logic        s_axi_rready,  // r ready
	input wire fsbe_pins_t  flash          // flash pins
);
	logic [7:0] last_cmd_reg; // byte of previous flash write
	logic [7:0] rd_addr_reg;  // address of read under way
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// helper state, so a confirm can be tied to the byte before it
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			last_cmd_reg <= 8'h00;
		else if ($fell(flash.we_n))
			last_cmd_reg <= flash.dq_o;
	// read address kept until its answer
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			rd_addr_reg <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			rd_addr_reg <= s_axi_araddr;
	sequence s_we_low;
		!flash.we_n [*8] ##1 !flash.we_n [*4];
	endsequence
	sequence s_we_end;
		flash.we_n && !flash.ce_n;
	endsequence
	a_aw_taken_once: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready stayed high after address taken");
	a_b_released: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid held after response taken");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_r_released: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid held after data taken");
	a_we_inside_ce: assert property (!flash.we_n |-> !flash.ce_n)
		else $error("write strobe outside chip enable");
	a_strobe_excl: assert property (!(!flash.we_n && !flash.oe_n))
		else $error("write and output enable together");
	a_we_pulse_width: assert property ($fell(flash.we_n) |-> s_we_low ##1 s_we_end)
		else $error("write strobe width wrong");
	a_addr_held: assert property (!flash.ce_n && !$past(flash.ce_n) |-> $stable(flash.addr))
		else $error("flash address moved in a cycle");
	a_confirm_after_setup: assert property (
		$fell(flash.we_n) && flash.dq_o == 8'hd0 |-> last_cmd_reg == 8'h20)
		else $error("confirm byte without setup byte");
	a_reserved_masked: assert property (
		s_axi_rvalid && rd_addr_reg == `FSBE_OFF_STATUS |-> !s_axi_rdata[0])
		else $error("reserved status bit not masked");
endmodule : fsbe_ctrl_props
bind fsbe_ctrl fsbe_ctrl_props u_fsbe_ctrl_props (.clk_sys(clk_sys), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .flash(flash));

/* tb/fsbe_flash_model.sv */
// Purpose: behavioural parallel flash, status and block erase only
// Assumes: commands latch on the rising write strobe
// Notes:   reserved bit 0 reads as one so masking is exercised
`timescale 1ns/1ps
module fsbe_flash_model
#(
	parameter int BUSY_NS = 300 // erase time, shortened
)
(
	input  wire logic        ce_n,       // chip enable
	input  wire logic        we_n,       // write strobe
	input  wire logic        oe_n,       // output enable
	input  wire logic [19:0] addr,       // address
	input  wire logic [7:0]  dq_in,      // resolved data wire
	input  wire logic        rst_pd_n,   // reset, low active
	input  wire logic        lock,       // target block locked
	input  wire logic        supply_low, // program supply low
	output logic [7:0]       dq_out,     // read data or noise
	output logic             rdy = 1'b1, // ready/busy pin
	output logic [19:0]      erase_addr, // last erased address
	output logic             array_mode  // array read mode
);
	logic [7:0] sr;           // sticky flags
	logic       setup;        // erase setup seen
	logic       stat;         // reads give status
	logic [7:0] held = 8'h00; // last value driven
	// command decoder; supply and lock looked at only on confirm
	always @(posedge we_n or negedge rst_pd_n)
	begin
		if (!rst_pd_n)
		begin
			sr = 8'h00;
			setup = 1'b0;
			stat = 1'b0;
			array_mode = 1'b1;
		end
		else if (!ce_n)
		begin
			array_mode = 1'b0;
			stat = 1'b1;
			if (setup)
			begin
				setup = 1'b0;
				if (dq_in != 8'hd0)
					sr[5:4] = 2'b11;
				else if (supply_low)
					sr = sr | 8'h28;
				else if (lock)
					sr = sr | 8'h22;
				else
				begin
					erase_addr = addr;
					rdy = 1'b0;
				end
			end
			else if (dq_in == 8'h20)
				setup = 1'b1;
			else if (dq_in == 8'h50)
				sr = sr & 8'hc5;
			else if (dq_in == 8'hff)
			begin
				array_mode = 1'b1;
				stat = 1'b0;
			end
		end
	end
	// erase engine finishes on its own after a fixed time
	always @(negedge rdy)
		rdy <= #BUSY_NS 1'b1;
	// data drive; released lines show the inverse, not a stale value
	always @*
	begin
		if (!ce_n && !oe_n)
		begin
			dq_out = stat ? {rdy, sr[6:1], 1'b1} : 8'h5a;
			held = dq_out;
		end
		else
			dq_out = ~held;
	end
endmodule : fsbe_flash_model

/* tb/fsbe_ctrl_tb.sv */
// Purpose: self-checking bench for the flash erase controller
// Assumes: model flash on the resolved data wire
// Notes:   offsets and bits from fsbe_consts.svh
`timescale 1ns/1ps
`include "fsbe_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module fsbe_ctrl_tb
	import fsbe_pkg::*;
;
	logic clk_sys = 0, rst_n = 0, lock = 0, supply_low = 0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, flash_dq_i, mdl_dq;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, reset_powerdown_n, ready_busy_out, irq, array_mode;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [19:0] erase_addr;
	fsbe_pins_t flash;
	int failures = 0, check_count = 0, cyc = 0;
	logic [31:0] st, d;
	// clock and wire resolution
	always #2.5 clk_sys = ~clk_sys;
	assign flash_dq_i = flash.dq_oe ? flash.dq_o : mdl_dq;
	fsbe_ctrl u_fsbe_ctrl (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash, .flash_dq_i, .reset_powerdown_n,
		.ready_busy_out, .irq);
	fsbe_flash_model u_fsbe_flash_model (.ce_n(flash.ce_n), .we_n(flash.we_n),
		.oe_n(flash.oe_n), .addr(flash.addr), .dq_in(flash_dq_i), .rst_pd_n(reset_powerdown_n),
		.lock, .supply_low, .dq_out(mdl_dq), .rdy(ready_busy_out), .erase_addr, .array_mode);
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bready <= 1'b0;
				`CHK(s_axi_bresp, er)
				return;
			end
		end while (1);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
			begin
				v = s_axi_rdata;
				s_axi_rready <= 1'b0;
				`CHK(s_axi_rresp, er)
				return;
			end
		end while (1);
	endtask : axi_rd
	// launch one operation and poll until the controller is idle
	task automatic run_op(input int b);
		int n;
		axi_wr(`FSBE_OFF_CTRL, 32'h1 << b, 2'b00);
		n = 0;
		st = 32'h100;
		while (st[`FSBE_ST_BUSY] && n < 300)
		begin
			axi_rd(`FSBE_OFF_STATUS, 2'b00, st);
			n++;
		end
		`CHK(st[`FSBE_ST_BUSY], 1'b0)
	endtask : run_op
	task automatic t_regs;
		`CHK(irq, 1'b0)
		`CHK(reset_powerdown_n, 1'b1)
		axi_rd(`FSBE_OFF_IRQ_STAT, 2'b00, d);
		`CHK(d[1:0], 2'b00)
		axi_rd(8'h18, 2'b10, d);
		axi_wr(`FSBE_OFF_STATUS, 32'h0, 2'b10);
		axi_wr(`FSBE_OFF_IRQ_EN, 32'h3, 2'b00);
		axi_rd(`FSBE_OFF_IRQ_EN, 2'b00, d);
		`CHK(d[1:0], 2'b11)
	endtask : t_regs
	task automatic t_erase_ok;
		axi_wr(`FSBE_OFF_ADDR, 32'h34567, 2'b00);
		run_op(`FSBE_CTRL_ERASE);
		`CHK(erase_addr, 20'h34567)
		`CHK(st[10:0], 11'h480)
		`CHK(array_mode, 1'b0)
		`CHK(irq, 1'b1)
		axi_wr(`FSBE_OFF_IRQ_EN, 32'h0, 2'b00);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		axi_rd(`FSBE_OFF_IRQ_STAT, 2'b00, d);
		`CHK(d[1:0], 2'b01)
		axi_wr(`FSBE_OFF_IRQ_CLR, 32'h3, 2'b00);
		axi_wr(`FSBE_OFF_IRQ_EN, 32'h3, 2'b00);
		repeat (2) @(posedge clk_sys);
		`CHK(irq, 1'b0)
	endtask : t_erase_ok
	// locked erase, then a clean one before the status check
	task automatic t_protect;
		lock <= 1'b1;
		run_op(`FSBE_CTRL_ERASE);
		`CHK(st[9:0], 10'h2a2)
		lock <= 1'b0;
		run_op(`FSBE_CTRL_ERASE);
		`CHK(st[7:0], 8'ha2)
		axi_rd(`FSBE_OFF_IRQ_STAT, 2'b00, d);
		`CHK(d[1:0], 2'b11)
		`CHK(irq, 1'b1)
		run_op(`FSBE_CTRL_CLRST);
		`CHK(st[7:0], 8'h00)
		run_op(`FSBE_CTRL_RDST);
		`CHK(st[7:0], 8'h80)
		axi_wr(`FSBE_OFF_IRQ_CLR, 32'h3, 2'b00);
	endtask : t_protect
	task automatic t_supply;
		supply_low <= 1'b1;
		run_op(`FSBE_CTRL_RDST);
		`CHK(st[7:0], 8'h80)
		run_op(`FSBE_CTRL_ERASE);
		`CHK(st[7:0], 8'ha8)
		supply_low <= 1'b0;
		run_op(`FSBE_CTRL_CLRST);
		run_op(`FSBE_CTRL_ARRAY);
		`CHK(array_mode, 1'b1)
	endtask : t_supply
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	// hang guard, far above the several hundred cycles needed
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_regs();
		t_erase_ok();
		t_protect();
		t_supply();
		tally_and_finish();
	end
endmodule : fsbe_ctrl_tb
